// [src/ccz_channel.sv]
`timescale 1ns/10ps
module ccz_channel (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    input wire logic auto_reload_select,
    input wire logic [1:0] pwm_resolution,
    input wire logic [15:0] counter_value,
    input wire logic counter_tick,
    input wire logic flag_clear,
    output logic channel_match_flag,
    output logic flag_irq,
    output logic comparator_enable,
    output logic channel_output_pin
);
    typedef struct packed {
        logic [7:0] mode;
        logic [15:0] cmp;
        logic [15:0] reload;
        logic flag;
        logic pin;
        logic [7:0] rdata;
    } ccz_state_t;

    ccz_state_t state_reg;
    ccz_state_t state_next;

    ccz_pkg::ccz_op_t op_now;
    logic cmp_wide;
    logic hit;
    logic wrap;
    logic active;
    logic low_wr;
    logic high_wr;
    logic [15:0] narrow_mask;

    function automatic ccz_pkg::ccz_op_t ccz_decode(input logic [7:0] mode);
        ccz_pkg::ccz_op_t op;
        op = ccz_pkg::CCZ_IDLE;
        if (mode[ccz_pkg::BIT_PWM] && mode[ccz_pkg::BIT_TOG]) begin
            op = ccz_pkg::CCZ_FREQ;
        end else if (mode[ccz_pkg::BIT_PWM]) begin
            op = mode[ccz_pkg::BIT_WIDE] ? ccz_pkg::CCZ_PWM_WIDE : ccz_pkg::CCZ_PWM_NARROW;
        end else if (mode[ccz_pkg::BIT_TOG]) begin
            op = ccz_pkg::CCZ_TOGGLE;
        end
        return op;
    endfunction

    always_comb begin
        op_now = ccz_decode(state_reg.mode);
        // Frequency output compares only the low byte; narrow modulation its own window
        cmp_wide = (op_now != ccz_pkg::CCZ_FREQ) && (op_now != ccz_pkg::CCZ_PWM_NARROW);
        active = counter_tick && state_reg.mode[ccz_pkg::BIT_CMP];
        low_wr = sfr_wr && (sfr_addr == ccz_pkg::LOW_ADDR);
        high_wr = sfr_wr && (sfr_addr == ccz_pkg::HIGH_ADDR);
        narrow_mask = ccz_pkg::ccz_mask(1'b0, pwm_resolution);
    end

    ccz_match u_match (
        .counter_value(counter_value),
        .compare_value(state_reg.cmp),
        .wide_sel(cmp_wide),
        .res_sel(op_now == ccz_pkg::CCZ_FREQ ? ccz_pkg::RES_8 : pwm_resolution),
        .match(hit),
        .rollover(wrap)
    );

    always_comb begin
        state_next = state_reg;

        // Register reads return one cycle after the strobe
        if (sfr_rd) begin
            case (sfr_addr)
                ccz_pkg::MODE_ADDR: state_next.rdata = state_reg.mode;
                ccz_pkg::LOW_ADDR: state_next.rdata = auto_reload_select ?
                    state_reg.reload[7:0] : state_reg.cmp[7:0];
                ccz_pkg::HIGH_ADDR: state_next.rdata = auto_reload_select ?
                    state_reg.reload[15:8] : state_reg.cmp[15:8];
                default: state_next.rdata = ccz_pkg::BYTE_RESET;
            endcase
        end

        if (active) begin
            case (op_now)
                ccz_pkg::CCZ_TOGGLE: begin
                    if (hit) begin
                        state_next.pin = ~state_reg.pin;
                    end
                end
                ccz_pkg::CCZ_PWM_NARROW: begin
                    if (wrap) begin
                        state_next.pin = 1'b1;
                        // New duty takes effect only at the window edge, avoiding glitches
                        if (pwm_resolution == ccz_pkg::RES_8) begin
                            state_next.cmp[7:0] = state_reg.cmp[15:8];
                        end else begin
                            state_next.cmp = (state_reg.cmp & ~narrow_mask) |
                                (state_reg.reload & narrow_mask);
                        end
                    end else if (hit) begin
                        state_next.pin = 1'b0;
                    end
                end
                ccz_pkg::CCZ_PWM_WIDE: begin
                    if (wrap) begin
                        state_next.pin = 1'b1;
                    end else if (hit) begin
                        state_next.pin = 1'b0;
                    end
                end
                ccz_pkg::CCZ_FREQ: begin
                    if (hit) begin
                        state_next.pin = ~state_reg.pin;
                        state_next.cmp[7:0] = state_reg.cmp[7:0] + state_reg.cmp[15:8];
                    end
                end
                default: begin
                    state_next.pin = state_reg.pin;
                end
            endcase
        end

        // Set wins over a clear in the same cycle
        if (flag_clear) begin
            state_next.flag = 1'b0;
        end
        if (active && hit && state_reg.mode[ccz_pkg::BIT_MAT]) begin
            state_next.flag = 1'b1;
        end

        // Software writes land after the engine so a write always sticks
        if (sfr_wr && (sfr_addr == ccz_pkg::MODE_ADDR)) begin
            state_next.mode = sfr_wdata;
        end
        if (low_wr) begin
            if (auto_reload_select) begin
                state_next.reload[7:0] = sfr_wdata;
            end else begin
                state_next.cmp[7:0] = sfr_wdata;
            end
            state_next.mode[ccz_pkg::BIT_CMP] = 1'b0;
        end
        if (high_wr) begin
            if (auto_reload_select) begin
                state_next.reload[15:8] = sfr_wdata;
            end else begin
                state_next.cmp[15:8] = sfr_wdata;
            end
            state_next.mode[ccz_pkg::BIT_CMP] = 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg.mode <= ccz_pkg::MODE_RESET;
            state_reg.cmp <= ccz_pkg::VALUE_RESET;
            state_reg.reload <= ccz_pkg::VALUE_RESET;
            state_reg.flag <= 1'b0;
            state_reg.pin <= 1'b0;
            state_reg.rdata <= ccz_pkg::BYTE_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    assign sfr_rdata = state_reg.rdata;
    assign channel_match_flag = state_reg.flag;
    assign comparator_enable = state_reg.mode[ccz_pkg::BIT_CMP];
    assign channel_output_pin = state_reg.pin;
    // Request is a level; it falls only when the flag is cleared or masked
    assign flag_irq = state_reg.flag && state_reg.mode[ccz_pkg::BIT_FLAG_INTERRUPT_ENABLE];

    sequence s_low_write;
        sfr_wr && (sfr_addr == ccz_pkg::LOW_ADDR);
    endsequence

    sequence s_high_write;
        sfr_wr && (sfr_addr == ccz_pkg::HIGH_ADDR);
    endsequence

    sequence s_hit_tick;
        active && hit;
    endsequence

    sequence s_freq_hit;
        active && hit && state_reg.mode[ccz_pkg::BIT_PWM] && state_reg.mode[ccz_pkg::BIT_TOG];
    endsequence

    chk_flag_set: assert property (@(posedge sys_clk) disable iff (!reset_n)
        s_hit_tick ##0 state_reg.mode[ccz_pkg::BIT_MAT] |=> channel_match_flag)
        else $error("match did not set the flag");

    chk_freq_decode: assert property (@(posedge sys_clk) disable iff (!reset_n)
        s_freq_hit |=> channel_output_pin != $past(channel_output_pin))
        else $error("frequency match did not invert pin");

    chk_pwm_rise: assert property (@(posedge sys_clk) disable iff (!reset_n)
        active && wrap && (op_now == ccz_pkg::CCZ_PWM_NARROW) |=> channel_output_pin)
        else $error("modulation output did not rise at wrap");

    chk_wide_fall: assert property (@(posedge sys_clk) disable iff (!reset_n)
        active && (op_now == ccz_pkg::CCZ_PWM_WIDE) && (counter_value == state_reg.cmp)
        && (counter_value != ccz_pkg::MASK_16) |=> !channel_output_pin)
        else $error("wide modulation did not fall on full match");

    chk_irq_gate: assert property (@(posedge sys_clk) disable iff (!reset_n)
        $rose(channel_match_flag) && $past(state_reg.mode[ccz_pkg::BIT_FLAG_INTERRUPT_ENABLE])
        && state_reg.mode[ccz_pkg::BIT_FLAG_INTERRUPT_ENABLE] |-> flag_irq)
        else $error("enabled flag gave no request");

    chk_low_clear: assert property (@(posedge sys_clk) disable iff (!reset_n)
        s_low_write |=> !comparator_enable)
        else $error("low byte write left comparator on");

    chk_high_set: assert property (@(posedge sys_clk) disable iff (!reset_n)
        s_high_write |=> comparator_enable)
        else $error("high byte write left comparator off");

    chk_high_byte: assert property (@(posedge sys_clk) disable iff (!reset_n)
        s_high_write ##0 !auto_reload_select |=> state_reg.cmp[15:8] == $past(sfr_wdata))
        else $error("high byte not stored as value MSB");

    chk_reload_path: assert property (@(posedge sys_clk) disable iff (!reset_n)
        s_low_write ##0 auto_reload_select |=> state_reg.reload[7:0] == $past(sfr_wdata))
        else $error("reload byte not stored");

    chk_toggle_flip: assert property (@(posedge sys_clk) disable iff (!reset_n)
        s_hit_tick ##0 (op_now == ccz_pkg::CCZ_TOGGLE)
        |=> channel_output_pin != $past(channel_output_pin))
        else $error("toggle match did not invert pin");

    chk_freq_step: assert property (@(posedge sys_clk) disable iff (!reset_n)
        s_freq_hit ##0 !low_wr |=> state_reg.cmp[7:0] ==
        8'($past(state_reg.cmp[7:0]) + $past(state_reg.cmp[15:8])))
        else $error("frequency point did not advance");

    chk_narrow_fall: assert property (@(posedge sys_clk) disable iff (!reset_n)
        active && hit && !wrap && (op_now == ccz_pkg::CCZ_PWM_NARROW)
        |=> !channel_output_pin)
        else $error("narrow modulation did not fall on match");

    chk_wide_rise: assert property (@(posedge sys_clk) disable iff (!reset_n)
        active && wrap && (op_now == ccz_pkg::CCZ_PWM_WIDE)
        |=> channel_output_pin)
        else $error("wide modulation did not rise at wrap");

    // A byte write in the wrap cycle wins, so it is excluded here
    chk_reload_apply: assert property (@(posedge sys_clk) disable iff (!reset_n)
        active && wrap && (op_now == ccz_pkg::CCZ_PWM_NARROW)
        && (pwm_resolution != ccz_pkg::RES_8) && !low_wr && !high_wr
        |=> (state_reg.cmp & $past(narrow_mask)) ==
        ($past(state_reg.reload) & $past(narrow_mask)))
        else $error("reload value not applied at wrap");

    chk_flag_clear: assert property (@(posedge sys_clk) disable iff (!reset_n)
        flag_clear && !(active && hit && state_reg.mode[ccz_pkg::BIT_MAT])
        |=> !channel_match_flag)
        else $error("flag clear was not taken");

    // A flag left from earlier stays, so only a clear flag is judged
    chk_flag_masked: assert property (@(posedge sys_clk) disable iff (!reset_n)
        s_hit_tick ##0 !state_reg.mode[ccz_pkg::BIT_MAT] ##0 !channel_match_flag
        |=> !channel_match_flag)
        else $error("flag set with match disabled");

    chk_low_byte: assert property (@(posedge sys_clk) disable iff (!reset_n)
        s_low_write ##0 !auto_reload_select |=> state_reg.cmp[7:0] == $past(sfr_wdata))
        else $error("low byte not stored as value LSB");

    chk_reload_high: assert property (@(posedge sys_clk) disable iff (!reset_n)
        s_high_write ##0 auto_reload_select |=> state_reg.reload[15:8] == $past(sfr_wdata))
        else $error("reload high byte not stored");

    // Read steering follows the select as it was at the strobe
    chk_read_steer: assert property (@(posedge sys_clk) disable iff (!reset_n)
        sfr_rd && (sfr_addr == ccz_pkg::LOW_ADDR)
        |=> sfr_rdata == ($past(auto_reload_select) ?
        $past(state_reg.reload[7:0]) : $past(state_reg.cmp[7:0])))
        else $error("low byte read took the wrong storage");

    // In toggle mode, ticks that miss must leave the pin alone
    chk_toggle_hold: assert property (@(posedge sys_clk) disable iff (!reset_n)
        active && !hit && (op_now == ccz_pkg::CCZ_TOGGLE)
        |=> $stable(channel_output_pin))
        else $error("toggle pin moved without a match");

endmodule

// [src/ccz_match.sv]
`timescale 1ns/10ps
module ccz_match (
    input wire logic [15:0] counter_value,
    input wire logic [15:0] compare_value,
    input wire logic wide_sel,
    input wire logic [1:0] res_sel,
    output logic match,
    output logic rollover
);
    logic [15:0] mask;

    always_comb begin
        mask = ccz_pkg::ccz_mask(wide_sel, res_sel);
        match = ((counter_value ^ compare_value) & mask) == 16'h0000;
        // All compared bits high: the next tick wraps the window
        rollover = (counter_value & mask) == mask;
    end
endmodule

// [src/ccz_pkg.sv]
package ccz_pkg;

    // Special-function register addresses
    localparam logic [7:0] MODE_ADDR = 8'hDA;
    localparam logic [7:0] LOW_ADDR = 8'hFB;
    localparam logic [7:0] HIGH_ADDR = 8'hFC;

    // Field positions in channel_mode_control
    localparam int BIT_WIDE = 7;
    localparam int BIT_CMP = 6;
    localparam int BIT_CAPP = 5;
    localparam int BIT_CAPN = 4;
    localparam int BIT_MAT = 3;
    localparam int BIT_TOG = 2;
    localparam int BIT_PWM = 1;
    localparam int BIT_FLAG_INTERRUPT_ENABLE = 0;

    // Reset values
    localparam logic [7:0] MODE_RESET = 8'h00;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [15:0] VALUE_RESET = 16'h0000;

    // Narrow modulation resolution codes
    localparam logic [1:0] RES_8 = 2'h0;
    localparam logic [1:0] RES_9 = 2'h1;
    localparam logic [1:0] RES_10 = 2'h2;
    localparam logic [1:0] RES_11 = 2'h3;

    // Comparison masks
    localparam logic [15:0] MASK_8 = 16'h00FF;
    localparam logic [15:0] MASK_9 = 16'h01FF;
    localparam logic [15:0] MASK_10 = 16'h03FF;
    localparam logic [15:0] MASK_11 = 16'h07FF;
    localparam logic [15:0] MASK_16 = 16'hFFFF;

    typedef enum logic [2:0] {
        CCZ_IDLE,
        CCZ_TOGGLE,
        CCZ_PWM_NARROW,
        CCZ_PWM_WIDE,
        CCZ_FREQ
    } ccz_op_t;

    // Bits of the counter that take part in a comparison
    function automatic logic [15:0] ccz_mask(input logic wide, input logic [1:0] res);
        logic [15:0] m;
        m = MASK_16;
        if (!wide) begin
            case (res)
                RES_8: m = MASK_8;
                RES_9: m = MASK_9;
                RES_10: m = MASK_10;
                RES_11: m = MASK_11;
                default: m = MASK_8;
            endcase
        end
        return m;
    endfunction

endpackage

// [verif/ccz_channel_tb.sv]
`timescale 1ns/10ps
module ccz_channel_tb;
    logic sys_clk;
    logic reset_n;
    logic [7:0] sfr_addr;
    logic sfr_wr;
    logic sfr_rd;
    logic [7:0] sfr_wdata;
    logic [7:0] sfr_rdata;
    logic auto_reload_select;
    logic [1:0] pwm_resolution;
    logic [15:0] counter_value;
    logic counter_tick;
    logic flag_clear;
    logic channel_match_flag;
    logic flag_irq;
    logic comparator_enable;
    logic channel_output_pin;
    logic [7:0] rd_val;
    int err_total;
    int tests_run;

    ccz_channel DUT (
        .sys_clk(sys_clk), .reset_n(reset_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
        .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
        .auto_reload_select(auto_reload_select), .pwm_resolution(pwm_resolution),
        .counter_value(counter_value), .counter_tick(counter_tick), .flag_clear(flag_clear),
        .channel_match_flag(channel_match_flag), .flag_irq(flag_irq),
        .comparator_enable(comparator_enable), .channel_output_pin(channel_output_pin)
    );

    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    task automatic complete_run();
        if (err_total == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic chk8(input string name, input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("FAIL %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic chk1(input string name, input logic exp, input logic got);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("FAIL %s expected %b seen %b", name, exp, got);
        end
    endtask

    // One idle cycle between strobes keeps each strobe a clean single pulse
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        @(negedge sys_clk);
        sfr_wr = 1'b0;
    endtask

    task automatic rd(input logic [7:0] a);
        @(negedge sys_clk);
        sfr_addr = a;
        sfr_rd = 1'b1;
        @(negedge sys_clk);
        sfr_rd = 1'b0;
        rd_val = sfr_rdata;
    endtask

    task automatic tick(input logic [15:0] v);
        @(negedge sys_clk);
        counter_value = v;
        counter_tick = 1'b1;
        @(negedge sys_clk);
        counter_tick = 1'b0;
    endtask

    // Low byte first, since the high byte write is what arms the comparator
    task automatic set_value(input logic [7:0] hi, input logic [7:0] lo);
        wr(ccz_pkg::LOW_ADDR, lo);
        wr(ccz_pkg::HIGH_ADDR, hi);
    endtask

    task automatic t_reset_regs();
        rd(ccz_pkg::MODE_ADDR);
        chk8("mode reset", ccz_pkg::MODE_RESET, rd_val);
        rd(ccz_pkg::LOW_ADDR);
        chk8("low reset", ccz_pkg::BYTE_RESET, rd_val);
        rd(ccz_pkg::HIGH_ADDR);
        chk8("high reset", ccz_pkg::BYTE_RESET, rd_val);
        rd(8'h00);
        chk8("unmapped read", 8'h00, rd_val);
        chk1("pin reset", 1'b0, channel_output_pin);
    endtask

    task automatic t_bytes();
        wr(ccz_pkg::HIGH_ADDR, 8'h12);
        chk1("enable after high", 1'b1, comparator_enable);
        wr(ccz_pkg::LOW_ADDR, 8'h34);
        chk1("enable after low", 1'b0, comparator_enable);
        rd(ccz_pkg::MODE_ADDR);
        chk8("mode bit6 cleared", 8'h00, rd_val);
        rd(ccz_pkg::HIGH_ADDR);
        chk8("high byte", 8'h12, rd_val);
        rd(ccz_pkg::LOW_ADDR);
        chk8("low byte", 8'h34, rd_val);
    endtask

    task automatic t_reload();
        auto_reload_select = 1'b1;
        wr(ccz_pkg::LOW_ADDR, 8'h55);
        wr(ccz_pkg::HIGH_ADDR, 8'h01);
        rd(ccz_pkg::LOW_ADDR);
        chk8("reload low", 8'h55, rd_val);
        rd(ccz_pkg::HIGH_ADDR);
        chk8("reload high", 8'h01, rd_val);
        auto_reload_select = 1'b0;
        rd(ccz_pkg::LOW_ADDR);
        chk8("value low kept", 8'h34, rd_val);
    endtask

    task automatic t_match();
        wr(ccz_pkg::MODE_ADDR, 8'h40);
        set_value(8'h12, 8'h34);
        tick(16'h1234);
        chk1("no flag without match enable", 1'b0, channel_match_flag);
        wr(ccz_pkg::MODE_ADDR, 8'h48);
        tick(16'h1235);
        chk1("no flag on mismatch", 1'b0, channel_match_flag);
        tick(16'h1234);
        chk1("flag on match", 1'b1, channel_match_flag);
        chk1("irq masked", 1'b0, flag_irq);
        wr(ccz_pkg::MODE_ADDR, 8'h49);
        chk1("irq enabled", 1'b1, flag_irq);
        @(negedge sys_clk);
        flag_clear = 1'b1;
        @(negedge sys_clk);
        flag_clear = 1'b0;
        chk1("flag cleared", 1'b0, channel_match_flag);
        chk1("irq follows flag", 1'b0, flag_irq);
    endtask

    task automatic t_toggle();
        wr(ccz_pkg::MODE_ADDR, 8'h44);
        set_value(8'h12, 8'h34);
        tick(16'h1234);
        chk1("toggle first", 1'b1, channel_output_pin);
        tick(16'h1200);
        chk1("toggle hold", 1'b1, channel_output_pin);
        tick(16'h1234);
        chk1("toggle second", 1'b0, channel_output_pin);
    endtask

    task automatic t_pwm();
        pwm_resolution = ccz_pkg::RES_8;
        wr(ccz_pkg::MODE_ADDR, 8'h42);
        set_value(8'h80, 8'h80);
        tick(16'h00FF);
        tick(16'h0100);
        tick(16'h0110);
        chk1("narrow high after wrap", 1'b1, channel_output_pin);
        tick(16'h0180);
        chk1("narrow low on match", 1'b0, channel_output_pin);
        wr(ccz_pkg::MODE_ADDR, 8'hC2);
        set_value(8'h80, 8'h80);
        tick(16'hFFFF);
        tick(16'h0000);
        tick(16'h0080);
        chk1("wide ignores low match", 1'b1, channel_output_pin);
        tick(16'h8080);
        chk1("wide low on match", 1'b0, channel_output_pin);
    endtask

    task automatic t_freq();
        wr(ccz_pkg::MODE_ADDR, 8'h46);
        set_value(8'h10, 8'h20);
        tick(16'h0020);
        chk1("freq toggle", 1'b1, channel_output_pin);
        tick(16'h0020);
        chk1("freq stale point", 1'b1, channel_output_pin);
        tick(16'h0030);
        chk1("freq next point", 1'b0, channel_output_pin);
        rd(ccz_pkg::LOW_ADDR);
        chk8("freq low advanced", 8'h40, rd_val);
    endtask

    task automatic t_pwm9();
        pwm_resolution = ccz_pkg::RES_9;
        wr(ccz_pkg::MODE_ADDR, 8'h42);
        auto_reload_select = 1'b1;
        set_value(8'h01, 8'h80);
        auto_reload_select = 1'b0;
        tick(16'h01FF);
        tick(16'h0040);
        chk1("nine bit ignores old point", 1'b1, channel_output_pin);
        tick(16'h0180);
        chk1("nine bit low on reload match", 1'b0, channel_output_pin);
        rd(ccz_pkg::LOW_ADDR);
        chk8("reload moved into value", 8'h80, rd_val);
    endtask

    initial begin
        repeat (5000) @(posedge sys_clk);
        err_total++;
        complete_run();
    end

    initial begin
        err_total = 0;
        tests_run = 0;
        reset_n = 1'b0;
        sfr_addr = 8'h00;
        sfr_wr = 1'b0;
        sfr_rd = 1'b0;
        sfr_wdata = 8'h00;
        auto_reload_select = 1'b0;
        pwm_resolution = 2'h0;
        counter_value = 16'h0000;
        counter_tick = 1'b0;
        flag_clear = 1'b0;
        repeat (8) @(posedge sys_clk);
        @(negedge sys_clk);
        reset_n = 1'b1;
        t_reset_regs();
        t_bytes();
        t_reload();
        t_match();
        t_toggle();
        t_pwm();
        t_freq();
        t_pwm9();
        complete_run();
    end
endmodule
